// ---- design/proc_status_flags.sv ----
`timescale 1ns/1ps
module proc_status_flags
   import proc_status_pkg::*;
(
   // Clock and reset.
   input  wire logic              clk_i,
   input  wire logic              nrst_i,
   // Conditions-out write, word bits numbered 0 (left) to 35 (right).
   input  wire logic              cono_valid_i,
   input  wire logic [0:35]       conditions_out_word_i,
   // Flag sources.
   input  wire logic              sbus_error_i,
   input  wire logic              nonexistent_memory_error_i,
   input  wire logic              sbus_adr_parity_error_i,
   input  wire logic              memory_buffer_parity_error_i,
   input  wire logic              cache_dir_parity_error_i,
   input  wire logic              io_page_fail_set_i,
   input  wire logic              power_warn_i,
   input  wire logic              sweep_busy_i,
   input  wire logic              power_loss_i,
   // Status view and interrupt request.
   output logic [FLAG_W-1:0]      status_flags_o,
   output logic [FLAG_W-1:0]      flag_interrupt_enables_o,
   output logic [CHAN_W-1:0]      irq_channel_o,
   output logic                   interrupt_req_o,
   // Returned to the memory control unit.
   output logic [FLAG_W-1:0]      error_hold_o,
   output logic                   any_error_hold_o
);
   // Status state and its next values.
   logic [FLAG_W-1:0] flags_q;
   logic [FLAG_W-1:0] flags_d;
   logic [FLAG_W-1:0] enables_q;
   logic [FLAG_W-1:0] enables_d;
   logic [CHAN_W-1:0] chan_q;
   logic [CHAN_W-1:0] chan_d;

   // Two-stage synchronisers, one pair for each source group, then the sweep history bit.
   logic [2:0]        adapter_sync1_q;
   logic [2:0]        adapter_q;
   logic [1:0]        memunit_sync1_q;
   logic [1:0]        memunit_q;
   logic              micro_sync1_q;
   logic              micro_q;
   logic              warn_sync1_q;
   logic              warn_q;
   logic              sweep_sync1_q;
   logic              sweep_q;
   logic              power_sync1_q;
   logic              power_q;
   logic              sweep_prev_q;

   // Decoded conditions-out command.
   logic [FLAG_W-1:0] sel;
   logic              cmd_en_set;
   logic              cmd_en_clr;
   logic              cmd_flag_set;
   logic              cmd_flag_clr;
   logic [FLAG_W-1:0] hw_set;
   logic              sweep_done;

   // Selector bits 24..31 mapped to flag index 0..7.
   function automatic logic [FLAG_W-1:0] pick_sel(input logic [0:35] w);
      logic [FLAG_W-1:0] s;
      s = '0;
      for (int i = 0; i < FLAG_W; i++) begin
         s[i] = w[BIT_SEL_FIRST + i];
      end
      return s;
   endfunction : pick_sel

   // Set takes priority over clear when one word carries both requests.
   function automatic logic [FLAG_W-1:0] apply_cmd(
      input logic [FLAG_W-1:0] cur,
      input logic [FLAG_W-1:0] mask,
      input logic              do_set,
      input logic              do_clr
   );
      logic [FLAG_W-1:0] r;
      r = cur;
      if (do_set) begin
         r = cur | mask;
      end else if (do_clr) begin
         r = cur & ~mask;
      end
      return r;
   endfunction : apply_cmd

   // Only the memory related flags hold the error address register.
   function automatic logic [FLAG_W-1:0] err_view(
      input logic [FLAG_W-1:0] f
   );
      return f & ERROR_MASK;
   endfunction : err_view

   assign sel = pick_sel(conditions_out_word_i);

   always_comb begin
      cmd_en_set   = 1'b0;
      cmd_en_clr   = 1'b0;
      cmd_flag_set = 1'b0;
      cmd_flag_clr = 1'b0;
      if (cono_valid_i) begin
         cmd_en_set   = conditions_out_word_i[BIT_EN_SET];
         cmd_en_clr   = conditions_out_word_i[BIT_EN_CLR];
         cmd_flag_set = conditions_out_word_i[BIT_FLAG_SET];
         cmd_flag_clr = conditions_out_word_i[BIT_FLAG_CLR];
      end
   end

   // Every source comes from another clock region or a pin, so each passes
   // two flip-flops. This costs two cycles beyond the single clock of
   // latency, traded for freedom from metastable flag updates.
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         adapter_sync1_q <= '0;
         adapter_q       <= '0;
      end else begin
         adapter_sync1_q <= {sbus_adr_parity_error_i,
                             nonexistent_memory_error_i,
                             sbus_error_i};
         adapter_q       <= adapter_sync1_q;
      end
   end

   // Buffer and directory parity come from the memory control unit.
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         memunit_sync1_q <= '0;
         memunit_q       <= '0;
      end else begin
         memunit_sync1_q <= {cache_dir_parity_error_i,
                             memory_buffer_parity_error_i};
         memunit_q       <= memunit_sync1_q;
      end
   end

   // The microprogram request for the page fail flag.
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         micro_sync1_q <= 1'b0;
         micro_q       <= 1'b0;
      end else begin
         micro_sync1_q <= io_page_fail_set_i;
         micro_q       <= micro_sync1_q;
      end
   end

   // The low voltage warning from the power controller.
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         warn_sync1_q <= 1'b0;
         warn_q       <= 1'b0;
      end else begin
         warn_sync1_q <= power_warn_i;
         warn_q       <= warn_sync1_q;
      end
   end

   // The cache sweep busy line.
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         sweep_sync1_q <= 1'b0;
         sweep_q       <= 1'b0;
      end else begin
         sweep_sync1_q <= sweep_busy_i;
         sweep_q       <= sweep_sync1_q;
      end
   end

   // The power loss line that wipes the enables.
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         power_sync1_q <= 1'b0;
         power_q       <= 1'b0;
      end else begin
         power_sync1_q <= power_loss_i;
         power_q       <= power_sync1_q;
      end
   end

   // The history bit resets to the idle level of the busy line, so that the
   // release of reset never looks like a finished sweep.
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         sweep_prev_q <= 1'b0;
      end else begin
         sweep_prev_q <= sweep_q;
      end
   end

   assign sweep_done = sweep_prev_q & ~sweep_q;

   always_comb begin
      hw_set                  = '0;
      hw_set[FL_SBUS]         = adapter_q[0];
      hw_set[FL_NOMEM]        = adapter_q[1];
      hw_set[FL_ADRPAR]       = adapter_q[2];
      hw_set[FL_MBPAR]        = memunit_q[0];
      hw_set[FL_CDIR]         = memunit_q[1];
      hw_set[FL_IO_PAGE_FAIL] = micro_q;
      hw_set[FL_POWER]        = warn_q;
      hw_set[FL_SWEEP]        = sweep_done;
   end

   // A hardware set in the same cycle as a clear wins, so no event is lost.
   always_comb begin
      flags_d = apply_cmd(flags_q, sel, cmd_flag_set,
                          cmd_flag_clr);
      flags_d = flags_d | hw_set;
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         flags_q <= FLAGS_RESET;
      end else begin
         flags_q <= flags_d;
      end
   end

   // Power loss wipes the enables, as their stored state would not survive.
   always_comb begin
      if (power_q) begin
         enables_d = ENABLE_RESET;
      end else begin
         enables_d = apply_cmd(enables_q, sel, cmd_en_set,
                               cmd_en_clr);
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         enables_q <= ENABLE_RESET;
      end else begin
         enables_q <= enables_d;
      end
   end

   // Every conditions-out write reloads the channel number.
   always_comb begin
      chan_d = chan_q;
      if (cono_valid_i) begin
         chan_d = conditions_out_word_i[BIT_CHAN_LAST-2:BIT_CHAN_LAST];
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         chan_q <= CHAN_RESET;
      end else begin
         chan_q <= chan_d;
      end
   end

   // Outputs are registered one cycle after the state they reflect, so that
   // every pin comes straight from a flip-flop.
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         status_flags_o <= '0;
      end else begin
         status_flags_o <= flags_q;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         flag_interrupt_enables_o <= '0;
      end else begin
         flag_interrupt_enables_o <= enables_q;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         irq_channel_o <= '0;
      end else begin
         irq_channel_o <= chan_q;
      end
   end

   // The request is a level; it drops as soon as software clears the flag.
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         interrupt_req_o <= 1'b0;
      end else begin
         interrupt_req_o <= |(flags_q & enables_q);
      end
   end

   // The hold stays up until software clears every error flag.
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         error_hold_o     <= '0;
         any_error_hold_o <= 1'b0;
      end else begin
         error_hold_o     <= err_view(flags_q);
         any_error_hold_o <= |err_view(flags_q);
      end
   end
endmodule : proc_status_flags

// ---- design/proc_status_pkg.sv ----
// Overview of operation
// - Two 8-bit registers hold status flags and their interrupt enables.
// - Flags and enables change only by conditions-out writes or sources.
// - Conditions-out bit 20 turns on enables selected by bits 24 to 31.
// - Conditions-out bit 21 turns off enables selected by bits 24 to 31.
// - Enables hold until disabled; power-up or power failure loses them.
// - Bit 23 sets, bit 22 clears the flags selected by bits 24 to 31.
// - Bits 24-31 select bus, memory, page, buffer, dir, addr, power, sweep.
// - Interrupt requested when any flag is set with its enable on.
// - Bus, memory, address parity from adapter; buffer, directory from unit.
// - Io page fail flag set by microprogram on interrupt-cycle page fault.
// - Power failure flag sets when power controller reports low voltage.
// - Sweep done flag sets when a started cache sweep completes.
// - Memory control unit errors set their flag on the following clock; here the flag sets on the third clock, after two synchroniser stages.
// - Set error flags return to memory unit; any-error holds the address.
package proc_status_pkg;
   localparam int unsigned FLAG_W       = 8;
   localparam int unsigned CHAN_W       = 3;
   localparam int unsigned WORD_W       = 36;
   // Bit positions use the left-to-right numbering of the 36-bit word.
   localparam int unsigned BIT_EN_SET   = 20;
   localparam int unsigned BIT_EN_CLR   = 21;
   localparam int unsigned BIT_FLAG_CLR = 22;
   localparam int unsigned BIT_FLAG_SET = 23;
   localparam int unsigned BIT_SEL_FIRST = 24;
   localparam int unsigned BIT_CHAN_LAST = 35;
   // Flag indices, index 0 is selector bit 24.
   localparam int unsigned FL_SBUS     = 0;
   localparam int unsigned FL_NOMEM    = 1;
   localparam int unsigned FL_IO_PAGE_FAIL = 2;
   localparam int unsigned FL_MBPAR    = 3;
   localparam int unsigned FL_CDIR     = 4;
   localparam int unsigned FL_ADRPAR   = 5;
   localparam int unsigned FL_POWER    = 6;
   localparam int unsigned FL_SWEEP    = 7;
   // Flags that count as errors holding the error address register.
   localparam logic [7:0] ERROR_MASK   = 8'h3f;
   localparam logic [7:0] FLAGS_RESET  = 8'h00;
   localparam logic [7:0] ENABLE_RESET = 8'h00;
   localparam logic [2:0] CHAN_RESET   = 3'h0;
endpackage : proc_status_pkg

// ---- testbench/proc_status_checker.sv ----
`timescale 1ns/1ps
module proc_status_checker
   import proc_status_pkg::*;
(
   // Every port of the design, watched only.
   input wire logic        clk_i, nrst_i, cono_valid_i, sweep_busy_i,
   input wire logic [0:35] conditions_out_word_i,
   input wire logic        sbus_error_i, nonexistent_memory_error_i,
   input wire logic        io_page_fail_set_i, power_warn_i, power_loss_i,
   input wire logic        memory_buffer_parity_error_i,
   input wire logic        cache_dir_parity_error_i, sbus_adr_parity_error_i,
   input wire logic [7:0]  status_flags_o, flag_interrupt_enables_o,
   input wire logic [7:0]  error_hold_o,
   input wire logic [2:0]  irq_channel_o,
   input wire logic        interrupt_req_o, any_error_hold_o
);
   logic [0:35] w;
   logic [7:0]  f, e, sel, s1, s2;
   logic [6:0]  src, h1, h2, h3, h4, hit;
   assign w = conditions_out_word_i;
   assign f = status_flags_o;
   assign e = flag_interrupt_enables_o;
   assign sel = {<<{w[24:31]}};
   assign src = {power_warn_i, sbus_adr_parity_error_i,
      cache_dir_parity_error_i, memory_buffer_parity_error_i,
      io_page_fail_set_i, nonexistent_memory_error_i, sbus_error_i};
   // A source is owed its flag only once it has crossed the synchroniser.
   assign hit = src & h1 & h2 & h3 & h4;
   always_ff @(posedge clk_i) begin
      {s2, s1} <= {s1, sel};
      {h4, h3, h2, h1} <= {h3, h2, h1, src};
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   sequence calm; (!power_loss_i) [*4]; endsequence
   sequence quiet; (src == 7'h00 && !sweep_busy_i) [*6]; endsequence
   a_req_level: assert property (interrupt_req_o == |(f & e))
      else $error("interrupt request disagrees with flags");
   a_en_set: assert property (calm ##0 (cono_valid_i && w[20])
      |-> ##2 (e & s2) == s2) else $error("enable set missed");
   a_en_clear: assert property (calm ##0 (cono_valid_i && w[21]
      && !w[20]) |-> ##2 (e & s2) == 8'h00) else $error("enable kept");
   a_flag_set: assert property (cono_valid_i && w[23]
      |-> ##2 (f & s2) == s2) else $error("flag set missed");
   a_flag_clear: assert property (quiet ##0 (cono_valid_i && w[22]
      && !w[23]) |-> ##2 (f & s2) == 8'h00) else $error("flag kept");
   a_chan_load: assert property (cono_valid_i
      |-> ##2 irq_channel_o == $past(w[33:35], 2)) else $error("bad channel");
   a_err_hold: assert property (error_hold_o == (f & ERROR_MASK)
      && any_error_hold_o == |error_hold_o) else $error("bad error hold");
   a_src_flag: assert property ((f[6:0] & hit) == hit)
      else $error("source did not set its flag");
endmodule : proc_status_checker

// ---- testbench/mem_side_model.sv ----
`timescale 1ns/1ps
module mem_side_model (
   input  wire logic       clk_i,
   input  wire logic [8:0] cmd_i,
   output logic      [8:0] src_o
);
   initial src_o = 9'h000;
   // Lines launch on the unit's own clock edge, never mid-cycle.
   // Address latching and word order stay inside the unit.
   always @(posedge clk_i) src_o <= cmd_i;
endmodule : mem_side_model

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
   logic        clk_i = 1'b0, nrst_i = 1'b0, cono_valid_i = 1'b0;
   logic [0:35] w = '0;
   logic [8:0]  cmd = '0, src;
   logic [7:0]  fl = '0, en = '0, flags, ens, hold;
   logic [2:0]  ch;
   logic        req, anye;
   int          fails = 0, total_checks = 0, cyc = 0, seed = 32'h162f, r;
   mem_side_model u_mem_side_model (.clk_i(clk_i), .cmd_i(cmd), .src_o(src));
   proc_status_flags u_proc_status_flags (.clk_i(clk_i), .nrst_i(nrst_i),
      .cono_valid_i(cono_valid_i), .conditions_out_word_i(w),
      .sbus_error_i(src[0]), .nonexistent_memory_error_i(src[1]),
      .io_page_fail_set_i(src[2]), .memory_buffer_parity_error_i(src[3]),
      .cache_dir_parity_error_i(src[4]), .sbus_adr_parity_error_i(src[5]),
      .power_warn_i(src[6]), .sweep_busy_i(src[7]), .power_loss_i(src[8]),
      .status_flags_o(flags), .flag_interrupt_enables_o(ens),
      .irq_channel_o(ch), .interrupt_req_o(req), .error_hold_o(hold),
      .any_error_hold_o(anye));
   initial forever #2 clk_i = ~clk_i;
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : tally_and_finish
   always @(posedge clk_i) if (++cyc == 1000) begin
      fails++;
      tally_and_finish();
   end
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      total_checks++;
      if (s !== e) begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task automatic step(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : step
   task automatic cono(input logic [3:0] op, input logic [7:0] s,
                       input logic [2:0] c);
      w = {20'h0, op, {<<{s}}, 1'b0, c};
      cono_valid_i = 1'b1;
      step(1);
      cono_valid_i = 1'b0;
      if (op[3]) en |= s; else if (op[2]) en &= ~s;
      if (op[0]) fl |= s; else if (op[1]) fl &= ~s;
      step(1);
      chk(flags, fl);
      chk(ens, en);
      chk({5'h0, ch}, {5'h0, c});
      chk({7'h0, req}, {7'h0, |(fl & en)});
      chk(hold, fl & 8'h3f);
      chk({7'h0, anye}, {7'h0, |(fl & 8'h3f)});
   endtask : cono
   initial begin
      step(4);
      nrst_i = 1'b1;
      step(1);
      chk(flags, 8'h00);
      chk(ens, 8'h00);
      $display("reset test done");
      repeat (24) begin
         r = $random(seed);
         cono(r[3:0], r[11:4], r[14:12]);
      end
      $display("conditions-out test done");
      cono(4'h2, 8'hff, 3'h1);
      for (int i = 0; i < 8; i++) begin
         cmd[i] = 1'b1;
         step(6);
         cmd[i] = 1'b0;
         step(8);
         fl[i] = 1'b1;
         chk(flags, fl);
      end
      cono(4'h8, 8'hff, 3'h5);
      $display("source test done");
      cmd[8] = 1'b1;
      step(6);
      cmd[8] = 1'b0;
      step(6);
      en = '0;
      chk(ens, en);
      $display("power loss test done");
      tally_and_finish();
   end
endmodule : tb_top
bind proc_status_flags proc_status_checker u_proc_status_checker (.*);
